// file: src/sew_dev_end.sv
// Purpose: eeprom device end, write path of the two-wire bidirectional mode
// Assumes: link pins are asynchronous and sampled by clk; memory is 128 x 8
// Notes: read modes are not served; a read select is left unacknowledged
//
// Contract
// - write starts: START, select byte, direction 0
// - acknowledge byte address, load as start location
// - transmit-only clock low: ack, but no change
// - byte write: one data byte, then STOP
// - one to eight bytes within one row
// - acknowledge each data byte in ninth clock
// - increment only low three address bits
// - master keeps pages within row, eight bytes; sew_host_end does not check, device wraps column
// - STOP after write starts program cycle
// - program cycle ignores all bus inputs
// - program cycle ends within ten milliseconds
// - master polls with START plus select byte
// - busy device does not acknowledge select
// - unanswered poll: master repeats START and select
// - finished device acknowledges select, continues normally
// - select byte: type, three ignored, direction
// - sample on scl rise, change while low
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.svh"
module sew_dev_end #(
    parameter int unsigned PROG_CYCLES = `SEW_PROG_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    sew_link_if.dev link, // two-wire link
    input wire logic [6:0] peekAddr, // memory inspection address
    output logic [7:0] peekData, // memory byte at peekAddr
    output logic progBusy, // program cycle running
    output logic progDone // program cycle finished
);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    // bit 2 scl, bit 1 sda, bit 0 transmit-only clock
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
            prev_q <= 3'h7;
        end else if (ce) begin
            meta_q <= {link.scl, link.sda, link.xmitOnlyClk};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    wire sclRise = sync_q[2] & ~prev_q[2];
    wire sclFall = ~sync_q[2] & prev_q[2];
    wire sclHeld = sync_q[2] & prev_q[2];
    wire startSeen = sclHeld & prev_q[1] & ~sync_q[1];
    wire stopSeen = sclHeld & ~prev_q[1] & sync_q[1];
    wire wrAllowed = sync_q[0];

    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    sew_pkg::sew_dev_state_e state_q;
    sew_pkg::sew_dev_state_e state_d;
    sew_pkg::sew_byte_t shift_q;
    logic [3:0] bitCnt_q;
    logic ackOe_q;
    logic [3:0] rowAddr_q;
    logic [2:0] col_q;
    logic [7:0] pageValid_q;
    logic [31:0] progCnt_q;
    logic progDone_q;
    logic [7:0] peek_q;
    sew_pkg::sew_byte_t pageData_q [`SEW_PAGE_BYTES];
    sew_pkg::sew_byte_t mem_q [`SEW_MEM_BYTES];

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire inProg = (state_q == sew_pkg::DEV_PROG);
    wire inXfer = (state_q == sew_pkg::DEV_SEL) | (state_q == sew_pkg::DEV_ADDR) | (state_q == sew_pkg::DEV_DATA);
    wire byteDone = inXfer & sclFall & (bitCnt_q == 4'h8) & ~ackOe_q;
    wire ackEnd = inXfer & sclFall & ackOe_q;
    // upper nibble is the type, next three ignored, lsb is direction
    wire selMatch = (shift_q[7:4] == `SEW_DEV_TYPE_ID) & ~shift_q[0];
    wire giveAck = (state_q == sew_pkg::DEV_SEL) ? selMatch : 1'b1;
    wire progEnd = inProg & (progCnt_q == PROG_CYCLES - 1);
    wire shiftNow = inXfer & sclRise & ~ackOe_q & (bitCnt_q != 4'h8);

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (inProg) begin
            // the bus is simply not looked at until the cycle ends
            if (progEnd) begin
                state_d = sew_pkg::DEV_IDLE;
            end
        end else if (stopSeen) begin
            if (state_q == sew_pkg::DEV_DATA) begin
                state_d = sew_pkg::DEV_PROG;
            end else begin
                state_d = sew_pkg::DEV_IDLE;
            end
        end else if (startSeen) begin
            state_d = sew_pkg::DEV_SEL;
        end else if (byteDone & ~giveAck) begin
            state_d = sew_pkg::DEV_IDLE;
        end else if (ackEnd) begin
            unique case (state_q)
                sew_pkg::DEV_SEL: state_d = sew_pkg::DEV_ADDR;
                sew_pkg::DEV_ADDR: state_d = sew_pkg::DEV_DATA;
                sew_pkg::DEV_DATA: state_d = sew_pkg::DEV_DATA;
                sew_pkg::DEV_IDLE: state_d = sew_pkg::DEV_IDLE;
                sew_pkg::DEV_PROG: state_d = sew_pkg::DEV_PROG;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sew_pkg::DEV_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // bit reception
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            bitCnt_q <= 4'h0;
        end else if (ce) begin
            if (startSeen | ackEnd | inProg) begin
                bitCnt_q <= 4'h0;
            end else if (shiftNow) begin
                shift_q <= {shift_q[6:0], sync_q[1]};
                bitCnt_q <= bitCnt_q + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // acknowledge drive
    // ----------------------------------------------------------------
    // driven from the fall after bit 8 to the fall after the ninth clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackOe_q <= 1'b0;
        end else if (ce) begin
            if (startSeen | stopSeen | ackEnd | inProg) begin
                ackOe_q <= 1'b0;
            end else if (byteDone & giveAck) begin
                ackOe_q <= 1'b1;
            end
        end
    end

    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe = ackOe_q;

    // ----------------------------------------------------------------
    // address counter and page latches
    // ----------------------------------------------------------------
    wire addrByte = byteDone & (state_q == sew_pkg::DEV_ADDR);
    wire dataByte = byteDone & (state_q == sew_pkg::DEV_DATA);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rowAddr_q <= 4'h0;
            col_q <= 3'h0;
            pageValid_q <= 8'h00;
        end else if (ce) begin
            if (addrByte) begin
                // bit 7 lies beyond the array and is dropped
                rowAddr_q <= shift_q[6:3];
                col_q <= shift_q[2:0];
                pageValid_q <= 8'h00;
            end else if (dataByte) begin
                col_q <= col_q + 3'h1;
                if (wrAllowed) begin
                    pageValid_q[col_q] <= 1'b1;
                end
            end else if (progEnd) begin
                pageValid_q <= 8'h00;
            end
        end
    end

    // a wrapped page overwrites its own earlier latch, as on the real part
    always_ff @(posedge clk) begin
        if (ce & dataByte & wrAllowed) begin
            pageData_q[col_q] <= shift_q;
        end
    end

    // ----------------------------------------------------------------
    // self-timed program cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progCnt_q <= 32'h0000_0000;
            progDone_q <= 1'b0;
        end else if (ce) begin
            progDone_q <= progEnd;
            if (inProg & ~progEnd) begin
                progCnt_q <= progCnt_q + 32'h0000_0001;
            end else begin
                progCnt_q <= 32'h0000_0000;
            end
        end
    end

    // cells take the whole page at the end; unreceived slots keep old data
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int i = 0; i < `SEW_PAGE_BYTES; i++) begin
                if (progEnd & pageValid_q[i]) begin
                    mem_q[{rowAddr_q, 3'(i)}] <= pageData_q[i];
                end
            end
            peek_q <= mem_q[peekAddr];
        end
    end

    assign peekData = peek_q;
    assign progBusy = inProg;
    assign progDone = progDone_q;

endmodule : sew_dev_end
`default_nettype wire

// file: src/sew_host_end.sv
// Purpose: bus master end issuing page writes and ack polling
// Assumes: scl made here from clk by a divider, standard 100 kHz rate
// Notes: data bytes flow through a small fifo; scl stalls when it runs dry
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.svh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module sew_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    input wire logic inValid, // write offered
    output logic inReady, // room for a word
    input wire logic [W-1:0] inData, // write data
    output logic outValid, // word available
    input wire logic outReady, // word taken
    output logic [W-1:0] outData // head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_q [D];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;

    wire [AW:0] fill = wrPtr_q - rdPtr_q;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    assign inReady = (fill != (AW+1)'(D));
    assign outValid = (fill != '0);
    assign outData = buf_q[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (ce) begin
            wrPtr_q <= wrPtr_q + (AW+1)'(push);
            rdPtr_q <= rdPtr_q + (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (ce & push) begin
            buf_q[wrPtr_q[AW-1:0]] <= inData;
        end
    end
endmodule : sew_fifo

// ----------------------------------------------------------------
// master
// ----------------------------------------------------------------
module sew_host_end (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    sew_link_if.mst link, // two-wire link
    input wire logic cmdValid, // write command offered
    output logic cmdReady, // command taken when idle
    input wire logic [6:0] cmdAddr, // first byte address
    input wire logic [3:0] cmdLen, // data bytes, 1 to 8
    input wire logic wrValid, // data byte offered
    output logic wrReady, // fifo has room
    input wire logic [7:0] wrData, // data byte
    input wire logic writeEnable, // level for transmit-only clock pin
    output logic busy, // command in progress
    output logic done, // write finished and polled ready
    output logic fail // select, address or data not acknowledged
);
    sew_pkg::sew_host_state_e st_q;
    logic [1:0] ph_q;
    logic [8:0] qtr_q;
    logic [1:0] seg_q;
    logic [2:0] bitIdx_q;
    logic [3:0] left_q;
    logic [6:0] addr_q;
    sew_pkg::sew_byte_t tx_q;
    logic ack_q;
    logic poll_q;
    logic fail_q;
    logic [1:0] sdaSync_q;
    logic scl_q;
    logic sdaLow_q;
    logic wen_q;
    logic done_q;
    logic failP_q;
    logic fifoValid;
    logic [7:0] fifoData;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire isIdle = (st_q == sew_pkg::HST_IDLE);
    wire isAck = (st_q == sew_pkg::HST_ACK);
    wire isStop = (st_q == sew_pkg::HST_STOP);
    wire needData = (seg_q == 2'h1) | ((seg_q == 2'h2) & (left_q != 4'h0));
    wire wantPop = isAck & (ph_q == 2'h3) & ack_q & ~poll_q & needData;
    // holding scl low is how the bus waits for the fifo
    wire stall = wantPop & ~fifoValid;
    wire tick = ~isIdle & (qtr_q == 9'(`SEW_QTR_CYCLES - 1)) & ~stall;
    wire groupEnd = tick & (ph_q == 2'h3);
    wire take = isIdle & cmdValid;
    wire sdaIn = sdaSync_q[1];
    wire sclHi = isIdle | (ph_q == 2'h1) | (ph_q == 2'h2) | (isStop & (ph_q == 2'h3));
    wire sdaDrv = ((st_q == sew_pkg::HST_START) & ph_q[1]) | ((st_q == sew_pkg::HST_BYTE) & ~tx_q[7])
        | (isStop & ~ph_q[1]);
    wire [7:0] selByte = {`SEW_DEV_TYPE_ID, 3'h0, 1'b0};

    sew_fifo #(.W(8), .D(`SEW_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .inValid(wrValid),
        .inReady(wrReady),
        .inData(wrData),
        .outValid(fifoValid),
        .outReady(wantPop & tick),
        .outData(fifoData)
    );

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaSync_q <= 2'h3;
            scl_q <= 1'b1;
            sdaLow_q <= 1'b0;
            wen_q <= 1'b0;
            done_q <= 1'b0;
            failP_q <= 1'b0;
        end else if (ce) begin
            sdaSync_q <= {sdaSync_q[0], link.sda};
            scl_q <= sclHi;
            sdaLow_q <= sdaDrv;
            wen_q <= writeEnable;
            done_q <= groupEnd & isStop & poll_q;
            failP_q <= groupEnd & isStop & fail_q;
        end
    end

    assign link.scl = scl_q;
    assign link.sdaMstOut = 1'b0;
    assign link.sdaMstOe = sdaLow_q;
    assign link.xmitOnlyClk = wen_q;
    assign cmdReady = isIdle;
    assign busy = ~isIdle;
    assign done = done_q;
    assign fail = failP_q;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qtr_q <= 9'h000;
        end else if (ce) begin
            if (isIdle | tick) begin
                qtr_q <= 9'h000;
            end else if (!stall) begin
                qtr_q <= qtr_q + 9'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sew_pkg::HST_IDLE;
            ph_q <= 2'h0;
            seg_q <= 2'h0;
            bitIdx_q <= 3'h0;
            left_q <= 4'h0;
            addr_q <= 7'h00;
            tx_q <= 8'hFF;
            ack_q <= 1'b0;
            poll_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (ce) begin
            if (take) begin
                st_q <= sew_pkg::HST_START;
                ph_q <= 2'h0;
                addr_q <= cmdAddr;
                left_q <= (cmdLen == 4'h0) ? 4'h0 : cmdLen - 4'h1;
                poll_q <= 1'b0;
                fail_q <= 1'b0;
            end else if (tick) begin
                ph_q <= ph_q + 2'h1;
                if (isAck & (ph_q == 2'h2)) begin
                    ack_q <= ~sdaIn;
                end
                if (ph_q == 2'h3) begin
                    unique case (st_q)
                        sew_pkg::HST_START: begin
                            st_q <= sew_pkg::HST_BYTE;
                            tx_q <= selByte;
                            seg_q <= 2'h0;
                            bitIdx_q <= 3'h0;
                        end
                        sew_pkg::HST_BYTE: begin
                            if (bitIdx_q == 3'h7) begin
                                st_q <= sew_pkg::HST_ACK;
                            end else begin
                                bitIdx_q <= bitIdx_q + 3'h1;
                                tx_q <= {tx_q[6:0], 1'b1};
                            end
                        end
                        sew_pkg::HST_ACK: begin
                            bitIdx_q <= 3'h0;
                            if (!ack_q) begin
                                if (poll_q) begin
                                    st_q <= sew_pkg::HST_START;
                                end else begin
                                    fail_q <= 1'b1;
                                    st_q <= sew_pkg::HST_STOP;
                                end
                            end else if (poll_q) begin
                                st_q <= sew_pkg::HST_STOP;
                            end else if (seg_q == 2'h0) begin
                                tx_q <= {1'b0, addr_q};
                                seg_q <= 2'h1;
                                st_q <= sew_pkg::HST_BYTE;
                            end else if (needData) begin
                                tx_q <= fifoData;
                                if (seg_q == 2'h2) begin
                                    left_q <= left_q - 4'h1;
                                end
                                seg_q <= 2'h2;
                                st_q <= sew_pkg::HST_BYTE;
                            end else begin
                                st_q <= sew_pkg::HST_STOP;
                            end
                        end
                        sew_pkg::HST_STOP: begin
                            if (!poll_q & !fail_q) begin
                                poll_q <= 1'b1;
                                st_q <= sew_pkg::HST_START;
                            end else begin
                                st_q <= sew_pkg::HST_IDLE;
                            end
                        end
                        sew_pkg::HST_IDLE: st_q <= sew_pkg::HST_IDLE;
                    endcase
                end
            end
        end
    end

endmodule : sew_host_end
`default_nettype wire

// file: src/sew_link_if.sv
// Purpose: two-wire link between bus master and eeprom device
// Assumes: open-drain data line with pull-up, resolved here
// Notes: scl and the transmit-only clock are driven by the master only
`timescale 1ns/1ps
`default_nettype none
interface sew_link_if;
    logic scl;
    logic xmitOnlyClk;
    logic sdaMstOut;
    logic sdaMstOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic sda;

    // wired-and with pull-up: any enabled low driver wins
    assign sda = ~((sdaMstOe & ~sdaMstOut) | (sdaDevOe & ~sdaDevOut));

    modport dev (input scl, input xmitOnlyClk, input sda, output sdaDevOut, output sdaDevOe);
    modport mst (output scl, output xmitOnlyClk, output sdaMstOut, output sdaMstOe, input sda);
endinterface : sew_link_if
`default_nettype wire

// file: src/sew_map.svh
// Purpose: constants shared by both ends of the serial eeprom write path
// Assumes: 100 MHz system clock on both ends
// Notes: times are kept in their own unit, cycle counts derived from them
`ifndef SEW_MAP_SVH
`define SEW_MAP_SVH

// ----------------------------------------------------------------
// identity and geometry
// ----------------------------------------------------------------
// arbitrary value, not the type code of any real part
`define SEW_DEV_TYPE_ID 4'h5
`define SEW_MEM_BYTES 128
`define SEW_PAGE_BYTES 8
`define SEW_FIFO_DEPTH 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SEW_CLK_KHZ 100000
`define SEW_PROG_TIME_MS 10
`define SEW_PROG_CYCLES (`SEW_PROG_TIME_MS * `SEW_CLK_KHZ)
`define SEW_SCL_KHZ 100
`define SEW_QTR_CYCLES (`SEW_CLK_KHZ / (`SEW_SCL_KHZ * 4))

`endif

// file: src/sew_pkg.sv
// Purpose: types shared by both ends of the serial eeprom write path
// Assumes: nothing beyond the map header
// Notes: one-hot state codes
package sew_pkg;
    typedef enum logic [4:0] {
        DEV_IDLE = 5'h01,
        DEV_SEL = 5'h02,
        DEV_ADDR = 5'h04,
        DEV_DATA = 5'h08,
        DEV_PROG = 5'h10
    } sew_dev_state_e;

    typedef enum logic [4:0] {
        HST_IDLE = 5'h01,
        HST_START = 5'h02,
        HST_BYTE = 5'h04,
        HST_ACK = 5'h08,
        HST_STOP = 5'h10
    } sew_host_state_e;

    typedef logic [7:0] sew_byte_t;
endpackage : sew_pkg

// file: verif/sew_link_chk.sv
// Purpose: protocol checks on the shared two-wire link
// Assumes: both ends run on clk
// Notes: bit count restarts at each START
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.svh"
module sew_link_chk (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic scl, // link clock
    input wire logic sda, // resolved data
    input wire logic sdaMstOe, // master pulls low
    input wire logic sdaDevOe, // device pulls low
    input wire logic sdaDevOut // device level
);
    logic sclQ;
    logic sdaQ;
    logic firstQ;
    logic [3:0] bitQ;
    logic [7:0] shQ;
    logic [10:0] ackQ;
    wire sclUp = scl & ~sclQ;
    wire startSeen = scl & sclQ & sdaQ & ~sda;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            firstQ <= 1'b0;
            bitQ <= 4'h0;
            shQ <= 8'h00;
            ackQ <= 11'h000;
        end else begin
            sclQ <= scl;
            sdaQ <= sda;
            ackQ <= sdaDevOe ? ackQ + 11'h001 : 11'h000;
            if (startSeen) begin
                bitQ <= 4'h0;
                firstQ <= 1'b1;
            end else if (sclUp) begin
                bitQ <= (bitQ == 4'h8) ? 4'h0 : bitQ + 4'h1;
                firstQ <= firstQ & (bitQ != 4'h8);
                shQ <= (bitQ == 4'h8) ? shQ : {shQ[6:0], sda};
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ack_start: assert property ($rose(sdaDevOe) |-> bitQ == 4'h8 && !sdaDevOut)
        else $error("ack started outside ninth bit");
    chk_ack_scl_low: assert property ($changed(sdaDevOe) |-> !scl)
        else $error("device sda moved while scl high");
    chk_ack_hold: assert property ($rose(scl) && sdaDevOe |-> sdaDevOe [*8])
        else $error("ack dropped in high phase");
    chk_ack_ninth: assert property (sclUp && sdaDevOe |-> bitQ == 4'h8)
        else $error("ack outside ninth bit");
    chk_sel_match: assert property (sclUp && sdaDevOe && firstQ |->
        shQ[7:4] == `SEW_DEV_TYPE_ID && !shQ[0])
        else $error("wrong select acknowledged");
    chk_mst_release: assert property (sclUp && bitQ == 4'h8 |-> !sdaMstOe)
        else $error("master holds sda in ack bit");
    chk_ack_length: assert property (ackQ <= 11'h3F2)
        else $error("ack held too long");
    chk_scl_high: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high too short");
    cover property (sclUp && sdaDevOe && firstQ);
    cover property (sclUp && bitQ == 4'h8 && firstQ && !sdaDevOe);
    cover property (sclUp && sdaDevOe && !firstQ);
endmodule : sew_link_chk
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: both link ends facing each other
// Assumes: short program cycle
// Notes: scl rate is fixed; the two commands take about 1.18 ms of the 1.5 ms limit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst_n, cmdValid, cmdReady, wrValid, wrReady, writeEnable;
    logic busy, done, fail, progBusy, progDone;
    logic [6:0] cmdAddr, peekAddr;
    logic [3:0] cmdLen;
    logic [7:0] wrData, peekData;
    int failCount, testsRun, doneN, run, maxRun;
    sew_link_if link ();
    sew_dev_end #(.PROG_CYCLES(2000)) sew_dev_end_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link),
        .peekAddr(peekAddr), .peekData(peekData), .progBusy(progBusy), .progDone(progDone));
    sew_host_end sew_host_end_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady),
        .wrData(wrData), .writeEnable(writeEnable), .busy(busy), .done(done), .fail(fail));
    sew_link_chk sew_link_chk_inst (.clk(clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
        .sdaMstOe(link.sdaMstOe), .sdaDevOe(link.sdaDevOe), .sdaDevOut(link.sdaDevOut));
    always @(posedge clk) begin
        doneN += (progDone === 1'b1);
        run = (progBusy === 1'b1) ? run + 1 : 0;
        maxRun = (run > maxRun) ? run : maxRun;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrapUp
    task automatic runCmd(input logic [6:0] a, input logic [3:0] n, input logic we);
        int k;
        @(negedge clk);
        check(cmdReady, 1'b1, "ready");
        cmdValid = 1'b1;
        cmdAddr = a;
        cmdLen = n;
        writeEnable = we;
        @(negedge clk);
        cmdValid = 1'b0;
        check(busy, 1'b1, "busy");
        check(cmdReady, 1'b0, "ready held");
        for (k = 0; k < 90000 && done !== 1'b1 && fail !== 1'b1; k++) begin
            @(negedge clk);
        end
        check(done, 1'b1, "done");
        check(fail, 1'b0, "fail");
    endtask : runCmd
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        @(negedge clk);
        peekAddr = a;
        @(negedge clk);
        check(peekData, exp, "cell");
    endtask : peek
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic pageWrap;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            wrValid = 1'b1;
            wrData = 8'hA0 + 8'(i);
        end
        @(negedge clk);
        wrValid = 1'b0;
        check(wrReady, 1'b0, "fifo full");
        runCmd(7'h17, 4'h3, 1'b1);
        peek(7'h17, 8'hA0);
        peek(7'h10, 8'hA1);
        peek(7'h11, 8'hA2);
        check(doneN, 1, "program cycles");
        check(maxRun, 2000, "program length");
    endtask : pageWrap
    task automatic inhibitWrite;
        runCmd(7'h10, 4'h1, 1'b0);
        peek(7'h10, 8'hA1);
        check(doneN, 2, "program cycles");
        check(wrReady, 1'b1, "fifo drained");
    endtask : inhibitWrite
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #1500000;
        failCount++;
        wrapUp();
    end
    initial begin
        {rst_n, cmdValid, wrValid, writeEnable, cmdAddr, cmdLen, wrData, peekAddr} = '0;
        {failCount, testsRun, doneN, run, maxRun} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        pageWrap();
        inhibitWrite();
        wrapUp();
    end
endmodule : tb_top
`default_nettype wire
